// File: src/rcm_pkg.sv
package rcm_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] RCM_ESC_OFFSET       = 8'h00;
  localparam logic [7:0] RCM_PORT_CTRL_OFFSET = 8'h04;
  localparam logic [7:0] RCM_MARKER_OFFSET    = 8'h08;
  localparam logic [7:0] RCM_GAP_SEL_OFFSET   = 8'h0C;
  localparam logic [7:0] RCM_GAP_FBIT_OFFSET  = 8'h10;
  localparam logic [7:0] RCM_STATUS_OFFSET    = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RCM_ESC_ES_ENABLE_BIT   = 0;
  localparam int RCM_ESC_GAPPED_SEL_BIT  = 1;
  localparam int RCM_PCTRL_PIN_CLOCK_BIT = 0;
  localparam int RCM_PCTRL_E1_BIT        = 1;
  localparam int RCM_GAP_FBIT_BIT        = 0;
  localparam int RCM_STAT_BUSY_LINE_BIT  = 0;
  localparam int RCM_STAT_BUSY_SYS_BIT   = 1;
  localparam int RCM_STAT_FRAME_LINE_BIT = 2;
  localparam int RCM_STAT_FRAME_SYS_BIT  = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RCM_ESC_RESET       = 32'h0000_0000;
  localparam logic [31:0] RCM_PORT_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RCM_MARKER_RESET    = 32'h0000_0000;
  localparam logic [31:0] RCM_GAP_SEL_RESET   = 32'h0000_0000;
  localparam logic [31:0] RCM_GAP_FBIT_RESET  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Frame geometry and domain indices
  // ----------------------------------------------------------------
  localparam logic [4:0] RCM_T1_LAST_CHANNEL = 5'h17;
  localparam logic [4:0] RCM_E1_LAST_CHANNEL = 5'h1F;
  localparam logic [2:0] RCM_CHANNEL_LSB     = 3'h7;
  localparam int         RCM_DOMAIN_LINE     = 0;
  localparam int         RCM_DOMAIN_SYSTEM   = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] marker_mask;
    logic [31:0] gapped_mask;
    logic        gapped_fbit;
    logic        gapped_mode;
    logic        pin_clock;
    logic        e1_mode;
  } rcm_cfg_t;

  typedef enum logic {RCM_SLOT_FBIT, RCM_SLOT_DATA} rcm_slot_t;

endpackage

// File: src/rcm_timing_gen.sv
module rcm_timing_gen
  import rcm_pkg::*;
(
  input  wire logic     link_clk,
  input  wire logic     nrst,
  input  wire logic     cfg_req,
  input  wire rcm_cfg_t cfg_hold,
  output logic          cfg_ack,
  input  wire logic     frame_sync,
  output logic          frame_seen,
  output logic          pin_out
);

  // ----------------------------------------------------------------
  // Reset and configuration crossing
  // ----------------------------------------------------------------
  logic      rst_s1;
  logic      link_nrst;
  logic      req_s1;
  logic      req_s2;
  logic      req_s3;
  rcm_cfg_t  cfg_link;
  rcm_slot_t slot;
  logic [4:0] chan;
  logic [2:0] bitc;
  logic       level;
  logic       gate;

  // Asynchronous assert, release aligned to the link clock
  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1    <= 1'b0;
      link_nrst <= 1'b0;
    end
    else
    begin
      rst_s1    <= 1'b1;
      link_nrst <= rst_s1;
    end
  end

  // Toggle handshake; held word is stable while the toggle is in flight
  always_ff @(posedge link_clk or negedge link_nrst)
  begin
    if (!link_nrst)
    begin
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      req_s3   <= 1'b0;
      cfg_link <= '0;
    end
    else
    begin
      req_s1 <= cfg_req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      if (req_s2 != req_s3)
        cfg_link <= cfg_hold;
    end
  end

  assign cfg_ack = req_s3;

  // ----------------------------------------------------------------
  // Slot counters
  // ----------------------------------------------------------------
  wire [4:0] last_channel   = cfg_link.e1_mode ? RCM_E1_LAST_CHANNEL : RCM_T1_LAST_CHANNEL;
  wire       end_of_channel = (bitc == RCM_CHANNEL_LSB);
  wire       end_of_frame   = end_of_channel && (chan == last_channel);
  wire [4:0] chan_inc       = 5'(chan + 5'h01);
  wire [2:0] bit_inc        = 3'(bitc + 3'h1);

  // T1 frame: F-bit then 24 channels; E1 frame: 32 channels
  wire rcm_slot_t next_slot = frame_sync ? (cfg_link.e1_mode ? RCM_SLOT_DATA : RCM_SLOT_FBIT) :
                              (slot == RCM_SLOT_DATA && end_of_frame && !cfg_link.e1_mode) ?
                              RCM_SLOT_FBIT : RCM_SLOT_DATA;
  wire [4:0] next_chan = (frame_sync || slot == RCM_SLOT_FBIT) ? 5'h00 :
                         end_of_frame ? 5'h00 : end_of_channel ? chan_inc : chan;
  wire [2:0] next_bit  = (frame_sync || slot == RCM_SLOT_FBIT) ? 3'h0 : bit_inc;
  wire       next_fbit = (next_slot == RCM_SLOT_FBIT);

  // ----------------------------------------------------------------
  // Pin functions
  // ----------------------------------------------------------------
  wire rx_channel_marker = !next_fbit && cfg_link.marker_mask[next_chan];
  wire chan_lsb_pulse    = !next_fbit && (next_bit == RCM_CHANNEL_LSB);
  wire gap_enable        = next_fbit ? cfg_link.gapped_fbit
                                     : cfg_link.gapped_mask[next_chan];
  wire next_level = cfg_link.pin_clock ? (!cfg_link.gapped_mode && chan_lsb_pulse)
                                       : rx_channel_marker;
  wire next_gate  = cfg_link.pin_clock && cfg_link.gapped_mode && gap_enable;

  // Counters and output flops, all on the timing clock
  always_ff @(posedge link_clk or negedge link_nrst)
  begin
    if (!link_nrst)
    begin
      slot       <= RCM_SLOT_DATA;
      chan       <= 5'h00;
      bitc       <= 3'h0;
      level      <= 1'b0;
      gate       <= 1'b0;
      frame_seen <= 1'b0;
    end
    else
    begin
      slot  <= next_slot;
      chan  <= next_chan;
      bitc  <= next_bit;
      level <= next_level;
      gate  <= next_gate;
      if (frame_sync)
        frame_seen <= 1'b1;
    end
  end

  // Gate passes while clock is low, so the gapped pulse sits in the low half
  wire rx_channel_clock_out = level | (gate & ~link_clk);
  assign pin_out = rx_channel_clock_out;

endmodule

// File: src/rcm_marker_clock_gen.sv
// Notes on behaviour
// - Pin carries marker or channel clock, selectable
// - Marker high/low per slot, 24 or 32
// - Marker timed by line or system clock
// - Gapped mode: N x 64kHz over selected channels
// - Channel clock pulses high in each LSB
// - Channel clock timed by line or system clock
// - Gapped-clock select bit picks clock mode
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
module rcm_marker_clock_gen
  import rcm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_line_clock,
  input  wire logic        rx_line_frame_sync,
  input  wire logic        rx_system_clock,
  input  wire logic        rx_system_frame_sync,
  output logic             rx_channel_pin
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes
  (
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0]  sel
  );
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        result[i*8 +: 8] = new_word[i*8 +: 8];
    end
    return result;
  endfunction

  // Word address match
  function automatic logic addr_is
  (
    input logic [7:0] adr,
    input logic [7:0] offset
  );
    return adr[7:2] == offset[7:2];
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] rx_elastic_store_control;
  logic [31:0] port_control;
  logic [31:0] marker_mask;
  logic [31:0] gapped_channel_select;
  logic [31:0] gapped_fbit_select;
  logic        dom_busy      [2];
  logic        dom_frame     [2];
  logic        dom_pin       [2];
  logic        dom_clock     [2];
  logic        dom_sync      [2];
  rcm_cfg_t    cfg_word;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------

  // Request in flight and not yet answered
  wire bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_write = bus_req && wb_we_i;

  // Register selects
  wire hit_esc    = addr_is(wb_adr_i, RCM_ESC_OFFSET);
  wire hit_pctrl  = addr_is(wb_adr_i, RCM_PORT_CTRL_OFFSET);
  wire hit_marker = addr_is(wb_adr_i, RCM_MARKER_OFFSET);
  wire hit_gapsel = addr_is(wb_adr_i, RCM_GAP_SEL_OFFSET);
  wire hit_gapf   = addr_is(wb_adr_i, RCM_GAP_FBIT_OFFSET);
  wire hit_status = addr_is(wb_adr_i, RCM_STATUS_OFFSET);

  // Write strobes
  wire wr_esc    = bus_write && hit_esc;
  wire wr_pctrl  = bus_write && hit_pctrl;
  wire wr_marker = bus_write && hit_marker;
  wire wr_gapsel = bus_write && hit_gapsel;
  wire wr_gapf   = bus_write && hit_gapf;

  // Implemented bits of the narrow registers
  localparam logic [31:0] ESC_MASK   = (32'h1 << RCM_ESC_ES_ENABLE_BIT) | (32'h1 << RCM_ESC_GAPPED_SEL_BIT);
  localparam logic [31:0] PCTRL_MASK = (32'h1 << RCM_PCTRL_PIN_CLOCK_BIT) | (32'h1 << RCM_PCTRL_E1_BIT);
  localparam logic [31:0] GAPF_MASK  = 32'h1 << RCM_GAP_FBIT_BIT;

  // Next register values
  wire [31:0] next_esc    = merge_bytes(rx_elastic_store_control, wb_dat_i, wb_sel_i) & ESC_MASK;
  wire [31:0] next_pctrl  = merge_bytes(port_control, wb_dat_i, wb_sel_i) & PCTRL_MASK;
  wire [31:0] next_marker = merge_bytes(marker_mask, wb_dat_i, wb_sel_i);
  wire [31:0] next_gapsel = merge_bytes(gapped_channel_select, wb_dat_i, wb_sel_i);
  wire [31:0] next_gapf   = merge_bytes(gapped_fbit_select, wb_dat_i, wb_sel_i) & GAPF_MASK;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------

  // Software-written control
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_elastic_store_control <= RCM_ESC_RESET;
      port_control             <= RCM_PORT_CTRL_RESET;
      marker_mask              <= RCM_MARKER_RESET;
      gapped_channel_select    <= RCM_GAP_SEL_RESET;
      gapped_fbit_select       <= RCM_GAP_FBIT_RESET;
    end
    else
    begin
      if (wr_esc)
        rx_elastic_store_control <= next_esc;
      if (wr_pctrl)
        port_control <= next_pctrl;
      if (wr_marker)
        marker_mask <= next_marker;
      if (wr_gapsel)
        gapped_channel_select <= next_gapsel;
      if (wr_gapf)
        gapped_fbit_select <= next_gapf;
    end
  end

  // Status word
  wire [31:0] status_word = (32'(dom_busy[RCM_DOMAIN_LINE])    << RCM_STAT_BUSY_LINE_BIT)
                          | (32'(dom_busy[RCM_DOMAIN_SYSTEM])  << RCM_STAT_BUSY_SYS_BIT)
                          | (32'(dom_frame[RCM_DOMAIN_LINE])   << RCM_STAT_FRAME_LINE_BIT)
                          | (32'(dom_frame[RCM_DOMAIN_SYSTEM]) << RCM_STAT_FRAME_SYS_BIT);

  // Read mux; unmapped addresses read zero
  wire [31:0] read_word = hit_esc    ? rx_elastic_store_control :
                          hit_pctrl  ? port_control :
                          hit_marker ? marker_mask :
                          hit_gapsel ? gapped_channel_select :
                          hit_gapf   ? gapped_fbit_select :
                          hit_status ? status_word : 32'h0000_0000;

  // One-cycle answer, ack drops the cycle after
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= read_word;
    end
  end

  // ----------------------------------------------------------------
  // Configuration word for the timing domains
  // ----------------------------------------------------------------

  // Control bits gathered into one word
  assign cfg_word.marker_mask = marker_mask;
  assign cfg_word.gapped_mask = gapped_channel_select;
  assign cfg_word.gapped_fbit = gapped_fbit_select[RCM_GAP_FBIT_BIT];
  assign cfg_word.gapped_mode = rx_elastic_store_control[RCM_ESC_GAPPED_SEL_BIT];
  assign cfg_word.pin_clock   = port_control[RCM_PCTRL_PIN_CLOCK_BIT];
  assign cfg_word.e1_mode     = port_control[RCM_PCTRL_E1_BIT];

  // Timing clocks and frame syncs by domain
  assign dom_clock[RCM_DOMAIN_LINE]   = rx_line_clock;
  assign dom_clock[RCM_DOMAIN_SYSTEM] = rx_system_clock;
  assign dom_sync[RCM_DOMAIN_LINE]    = rx_line_frame_sync;
  assign dom_sync[RCM_DOMAIN_SYSTEM]  = rx_system_frame_sync;

  // ----------------------------------------------------------------
  // One timing generator per candidate clock
  // ----------------------------------------------------------------
  for (genvar d = 0; d < 2; d++)
  begin : g_dom
    logic     req;
    logic     ack;
    logic     ack_s1;
    logic     ack_s2;
    logic     frame_raw;
    logic     frame_s1;
    logic     frame_s2;
    rcm_cfg_t hold;

    // Toggle outstanding until the echo returns
    wire busy    = (req != ack_s2);
    wire changed = (cfg_word != hold);

    // Launch a new word only when idle
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        req  <= 1'b0;
        hold <= '0;
      end
      else if (!busy && changed)
      begin
        hold <= cfg_word;
        req  <= ~req;
      end
    end

    // Echo and frame flag back into the bus clock
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        ack_s1   <= 1'b0;
        ack_s2   <= 1'b0;
        frame_s1 <= 1'b0;
        frame_s2 <= 1'b0;
      end
      else
      begin
        ack_s1   <= ack;
        ack_s2   <= ack_s1;
        frame_s1 <= frame_raw;
        frame_s2 <= frame_s1;
      end
    end

    assign dom_busy[d]  = busy || changed;
    assign dom_frame[d] = frame_s2;

    rcm_timing_gen u_gen
    (
      .link_clk   (dom_clock[d]),
      .nrst       (nrst),
      .cfg_req    (req),
      .cfg_hold   (hold),
      .cfg_ack    (ack),
      .frame_sync (dom_sync[d]),
      .frame_seen (frame_raw),
      .pin_out    (dom_pin[d])
    );
  end

  // ----------------------------------------------------------------
  // Pin source selection
  // ----------------------------------------------------------------

  // Elastic store on: system clock timing, else line clock
  wire es_enable = rx_elastic_store_control[RCM_ESC_ES_ENABLE_BIT];

  assign rx_channel_pin = es_enable ? dom_pin[RCM_DOMAIN_SYSTEM]
                                    : dom_pin[RCM_DOMAIN_LINE];

endmodule

// File: dv/rcm_link_source.sv
module rcm_link_source
  import rcm_pkg::*;
#(
  parameter real HALF_NS  = 6.0,
  parameter real PHASE_NS = 0.0,
  parameter int  START    = 0
)
(
  input  wire logic         nrst,
  input  wire logic [8:0]   frame_len,
  input  wire logic         pin,
  output logic              link_clk,
  output logic              frame_sync,
  output logic [255:0]      cap
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Framer side: clock, frame sync, per-bit capture
  // ----------------------------------------------------------------
  logic [8:0] cnt;
  logic       mid;
  // Free-running recovered clock
  initial
  begin
    link_clk = 1'b0;
    #(PHASE_NS);
    forever #(HALF_NS) link_clk = ~link_clk;
  end
  // Sample mid low half, clear of both edges
  always @(negedge link_clk)
  begin
    #(HALF_NS / 2);
    mid = pin;
  end
  // Sync one bit ahead of bit 0, store each ended bit
  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt        <= 9'(START);
      frame_sync <= 1'b0;
    end
    else
    begin
      cap[cnt]   <= mid;
      cnt        <= (cnt >= frame_len - 9'h001) ? 9'h000 : cnt + 9'h001;
      frame_sync <= (cnt == frame_len - 9'h002);
    end
  end
endmodule

// File: dv/rcm_marker_clock_gen_asserts.sv
module rcm_marker_clock_gen_chk
  import rcm_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rx_line_clock,
  input wire logic        rx_line_frame_sync,
  input wire logic        rx_system_clock,
  input wire logic        rx_system_frame_sync,
  input wire logic        rx_channel_pin
);
  // ----------------------------------------------------------------
  // Mode shadow and settle counter
  // ----------------------------------------------------------------
  logic [5:0] quiet_cnt;
  logic       es;
  logic       gap;
  logic       pclk;
  wire        wr_ok   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire        quiet   = quiet_cnt == 6'h3F;
  wire        line_on = quiet & ~es;
  wire        sys_on  = quiet & es;
  wire        m_chclk = pclk & ~gap;
  wire        m_gap   = pclk & gap;
  // Track mode writes; any write restarts the settle time
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      quiet_cnt <= 6'h00;
      es        <= 1'b0;
      gap       <= 1'b0;
      pclk      <= 1'b0;
    end
    else
    begin
      quiet_cnt <= (wb_cyc_i & wb_stb_i & wb_we_i) ? 6'h00 : quiet_cnt + 6'(!quiet);
      if (wr_ok && wb_adr_i[7:2] == RCM_ESC_OFFSET[7:2])
      begin
        es  <= wb_dat_i[RCM_ESC_ES_ENABLE_BIT];
        gap <= wb_dat_i[RCM_ESC_GAPPED_SEL_BIT];
      end
      if (wr_ok && wb_adr_i[7:2] == RCM_PORT_CTRL_OFFSET[7:2])
        pclk <= wb_dat_i[RCM_PCTRL_PIN_CLOCK_BIT];
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_low_seven;
    !rx_channel_pin [*7];
  endsequence
  a_ack_next_cycle: assert property (@(posedge clk) disable iff (!nrst)
    s_req |=> wb_ack_o) else $error("ack late");
  a_ack_one_pulse: assert property (@(posedge clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_no_request: assert property (@(posedge clk) disable iff (!nrst)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack unasked");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
    s_req ##0 (!wb_we_i && wb_adr_i[7:2] > 6'h05) |=> wb_dat_o == 32'h0) else $error("unmapped read");
  a_line_clk_pulse: assert property (@(posedge rx_line_clock) disable iff (!nrst)
    line_on && m_chclk && $rose(rx_channel_pin) |=> s_low_seven) else $error("line pulse");
  a_sys_clk_pulse: assert property (@(posedge rx_system_clock) disable iff (!nrst)
    sys_on && m_chclk && $rose(rx_channel_pin) |=> s_low_seven) else $error("system pulse");
  a_line_mark_hold: assert property (@(posedge rx_line_clock) disable iff (!nrst)
    line_on && !pclk && $rose(rx_channel_pin) |-> rx_channel_pin [*8]) else $error("line marker");
  a_sys_mark_hold: assert property (@(posedge rx_system_clock) disable iff (!nrst)
    sys_on && !pclk && $rose(rx_channel_pin) |-> rx_channel_pin [*8]) else $error("system marker");
  a_line_gap_low: assert property (@(negedge rx_line_clock) disable iff (!nrst)
    line_on && m_gap |-> !rx_channel_pin) else $error("line gapped high");
  a_sys_gap_low: assert property (@(negedge rx_system_clock) disable iff (!nrst)
    sys_on && m_gap |-> !rx_channel_pin) else $error("system gapped high");
endmodule

bind rcm_marker_clock_gen rcm_marker_clock_gen_chk u_rcm_marker_clock_gen_chk
(
  .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_line_clock(rx_line_clock), .rx_line_frame_sync(rx_line_frame_sync),
  .rx_system_clock(rx_system_clock), .rx_system_frame_sync(rx_system_frame_sync),
  .rx_channel_pin(rx_channel_pin)
);

// File: dv/test_rcm_marker_clock_gen.sv
module test_rcm_marker_clock_gen
  import rcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Bus master, pin checks, verdict
  // ----------------------------------------------------------------
  logic         clk, nrst, cyc, stb, we, ack, pin, l_clk, l_sync, s_clk, s_sync;
  logic [7:0]   adr;
  logic [3:0]   sel;
  logic [31:0]  wdat, dat_o, rd;
  logic [8:0]   flen;
  logic [255:0] l_cap, s_cap;
  rcm_cfg_t     cfg_tab [6];
  logic [5:0]   es_tab;
  int           err_total = 0;
  int           n_tests = 0;

  rcm_marker_clock_gen u_rcm_marker_clock_gen
  (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_line_clock(l_clk),
    .rx_line_frame_sync(l_sync), .rx_system_clock(s_clk), .rx_system_frame_sync(s_sync),
    .rx_channel_pin(pin)
  );
  rcm_link_source #(.HALF_NS(6.0), .PHASE_NS(3.3), .START(0)) u_rcm_link_source
  (.nrst(nrst), .frame_len(flen), .pin(pin), .link_clk(l_clk), .frame_sync(l_sync), .cap(l_cap));
  rcm_link_source #(.HALF_NS(6.0), .PHASE_NS(7.1), .START(100)) u_rcm_link_source_sys
  (.nrst(nrst), .frame_len(flen), .pin(pin), .link_clk(s_clk), .frame_sync(s_sync), .cap(s_cap));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_frame(input logic [255:0] got, input logic [255:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected frame at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is seen
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
      err_total++;
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wb_chk(input logic [7:0] a, input logic [31:0] e);
    wb_cycle(1'b0, a, 32'h0, 4'hF);
    cmp_word(rd, e);
  endtask

  // Expected pin level of each bit of one frame
  function automatic logic [255:0] exp_frame(input rcm_cfg_t c);
    logic [255:0] f;
    int           ch;
    f = '0;
    for (int i = 0; i < (c.e1_mode ? 256 : 193); i++)
    begin
      ch = c.e1_mode ? i / 8 : (i - 1) / 8;
      if (!c.e1_mode && i == 0)
        f[i] = c.pin_clock & c.gapped_mode & c.gapped_fbit;
      else if (!c.pin_clock)
        f[i] = c.marker_mask[ch];
      else if (c.gapped_mode)
        f[i] = c.gapped_mask[ch];
      else
        f[i] = ((c.e1_mode ? i : i - 1) % 8) == 7;
    end
    return f;
  endfunction

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    rcm_cfg_t c;
    nrst = 1'b0;
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    adr  = 8'h00;
    sel  = 4'h0;
    wdat = 32'h0;
    flen = 9'h0C1;
    es_tab     = 6'h2A;
    cfg_tab[0] = '{32'h0080_0001, 32'h0, 1'h0, 1'h0, 1'h0, 1'h0};
    cfg_tab[1] = '{32'h8000_0001, 32'h0, 1'h0, 1'h0, 1'h0, 1'h1};
    cfg_tab[2] = '{32'h0, 32'h0, 1'h0, 1'h0, 1'h1, 1'h0};
    cfg_tab[3] = '{32'h0, 32'h0, 1'h0, 1'h0, 1'h1, 1'h1};
    cfg_tab[4] = '{32'hFFFF_FFFF, 32'h0080_0005, 1'h1, 1'h1, 1'h1, 1'h0};
    cfg_tab[5] = '{32'h0, 32'h8000_0003, 1'h0, 1'h1, 1'h1, 1'h1};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 5; a++)
      wb_chk(8'(a * 4), 32'h0); // Reset values
    wb_cycle(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    wb_chk(8'h40, 32'h0); // Unmapped place
    wb_cycle(1'b1, RCM_MARKER_OFFSET, 32'hFFFF_FFFF, 4'hF);
    wb_cycle(1'b1, RCM_MARKER_OFFSET, 32'h0000_3C00, 4'h2);
    wb_chk(RCM_MARKER_OFFSET, 32'hFFFF_3CFF); // One byte lane
    for (int k = 0; k < 6; k++)
    begin
      c = cfg_tab[k];
      flen <= c.e1_mode ? 9'h100 : 9'h0C1;
      wb_cycle(1'b1, RCM_PORT_CTRL_OFFSET, {30'h0, c.e1_mode, c.pin_clock}, 4'hF);
      wb_cycle(1'b1, RCM_MARKER_OFFSET, c.marker_mask, 4'hF);
      wb_cycle(1'b1, RCM_GAP_SEL_OFFSET, c.gapped_mask, 4'hF);
      wb_cycle(1'b1, RCM_GAP_FBIT_OFFSET, {31'h0, c.gapped_fbit}, 4'hF);
      wb_cycle(1'b1, RCM_ESC_OFFSET, {30'h0, c.gapped_mode, es_tab[k]}, 4'hF);
      wb_chk(RCM_ESC_OFFSET, {30'h0, c.gapped_mode, es_tab[k]}); // Mode readback
      for (int n = 0; n < 100 && !(rd[1:0] === 2'h0 && n > 0); n++)
        wb_cycle(1'b0, RCM_STATUS_OFFSET, 32'h0, 4'hF);
      cmp_word({30'h0, rd[1:0]}, 32'h0); // Config applied
      repeat (300) @(posedge clk);
      cmp_frame((es_tab[k] ? s_cap : l_cap) & ({256{1'b1}} >> (c.e1_mode ? 0 : 63)),
                exp_frame(c)); // Pin per bit
    end
    wb_cycle(1'b1, RCM_STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF);
    wb_chk(RCM_STATUS_OFFSET, 32'h0000_000C); // Read-only status, both syncs seen
    report_and_stop();
  end
endmodule
